// ===== hw/ssp_port.sv
// serial peripheral port: registers, prescalers, shifter and frame sync
`timescale 1ns/10ps
`include "ssp_defines.svh"

module ssp_port (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // device idle indication
    input wire logic dev_idle,
    // register port
    input wire ssp_pkg::ssp_req_t req,
    output logic [15:0] rdata,
    // serial pins
    input wire ssp_pkg::ssp_pins_in_t pins_in,
    output ssp_pkg::ssp_pins_out_t pins_out,
    // events
    output ssp_pkg::ssp_events_t events,
    input wire logic done_enable
);
    import ssp_pkg::*;

    typedef struct packed {
        ssp_state_t st;
        logic [15:0] stat;
        logic [15:0] con1;
        logic [15:0] con2;
        logic [15:0] shreg;
        logic [15:0] txb;
        logic [15:0] rxb;
        logic [4:0] bitcnt;
        logic [7:0] div;
        logic sck_int;
        logic sck_prev;
        logic ss_prev;
        logic fs_pend;
        logic [15:0] rdata;
        ssp_pins_out_t pins;
        ssp_events_t ev;
    } ssp_state_all_t;

    ssp_state_all_t s_r;
    ssp_state_all_t s_nxt;

    // primary ratio 1,4,16,64 from its two-bit code
    function automatic logic [7:0] prim_ratio(input logic [1:0] code);
        unique case (code)
            2'h3: prim_ratio = 8'h01;
            2'h2: prim_ratio = 8'h04;
            2'h1: prim_ratio = 8'h10;
            2'h0: prim_ratio = 8'h40;
        endcase
    endfunction

    // half period in core clocks; product of both ratios, halved, at least one
    function automatic logic [8:0] half_period(input logic [15:0] c1);
        logic [11:0] full;
        full = 12'(prim_ratio(c1[`SSP_C1_PPRE_LO +: 2]))
            * 12'(4'h8 - {1'b0, c1[`SSP_C1_SPRE_LO +: 3]});
        half_period = (full[11:1] == 11'h000) ? 9'h001 : full[9:1];
    endfunction

    logic en;
    logic master;
    logic halted;
    logic [4:0] nbits;
    logic framed;
    logic fs_act;
    logic ss_ok;
    logic sck_pin;
    logic lead_edge;
    logic trail_edge;
    logic [8:0] hp;

    // decoded controls
    always_comb begin
        en = s_r.stat[`SSP_STAT_EN];
        master = s_r.con1[`SSP_C1_MASTER_SELECT];
        halted = s_r.stat[`SSP_STAT_SIDL] & dev_idle;
        nbits = s_r.con1[`SSP_C1_WORD_SIZE_SELECT] ? `SSP_BITS_WORD : `SSP_BITS_BYTE;
        framed = s_r.con2[`SSP_C2_FRAMED_MODE_ENABLE];
        // sync level as seen on the select pin
        fs_act = s_r.con2[`SSP_C2_FPOL] ? pins_in.ss_i : ~pins_in.ss_i;
        ss_ok = ~s_r.con1[`SSP_C1_SELECT_INPUT_ENABLE] | ~pins_in.ss_i | framed;
        // clock level normalised to idle-low, then edges
        sck_pin = pins_in.sck_i ^ s_r.con1[`SSP_C1_CKP];
        lead_edge = sck_pin & ~s_r.sck_prev;
        trail_edge = ~sck_pin & s_r.sck_prev;
        hp = half_period(s_r.con1);
    end

    // next-state logic for the whole block
    always_comb begin
        logic do_sample;
        logic do_shift;
        logic word_end;
        logic cke;
        do_sample = 1'b0;
        do_shift = 1'b0;
        word_end = 1'b0;
        cke = s_r.con1[`SSP_C1_CKE] & ~framed;
        s_nxt = s_r;
        s_nxt.ev.done_flag = 1'b0;
        s_nxt.ev.err_irq = 1'b0;
        s_nxt.sck_prev = sck_pin;
        s_nxt.ss_prev = fs_act;
        s_nxt.rdata = 16'h0000;

        // register reads; buffer read empties the receive side
        if (req.rd) begin
            unique case (req.addr)
                `SSP_ADDR_STAT: s_nxt.rdata = s_r.stat;
                `SSP_ADDR_CON1: s_nxt.rdata = s_r.con1;
                `SSP_ADDR_CON2: s_nxt.rdata = s_r.con2;
                `SSP_ADDR_BUF: begin
                    s_nxt.rdata = s_r.rxb;
                    s_nxt.stat[`SSP_STAT_RBF] = 1'b0;
                    s_nxt.stat[`SSP_STAT_ROV] = 1'b0;
                end
                default: s_nxt.rdata = 16'h0000;
            endcase
        end
        // register writes; overflow is write-zero-to-clear
        if (req.wr) begin
            unique case (req.addr)
                `SSP_ADDR_STAT: begin
                    s_nxt.stat = (s_r.stat & ~`SSP_STAT_WMASK) | (req.wdata & `SSP_STAT_WMASK);
                    if (!req.wdata[`SSP_STAT_ROV]) begin
                        s_nxt.stat[`SSP_STAT_ROV] = 1'b0;
                    end
                end
                `SSP_ADDR_CON1: s_nxt.con1 = req.wdata & `SSP_C1_WMASK;
                `SSP_ADDR_CON2: s_nxt.con2 = req.wdata & `SSP_C2_WMASK;
                `SSP_ADDR_BUF: begin
                    s_nxt.txb = req.wdata;
                    s_nxt.stat[`SSP_STAT_TBF] = 1'b1;
                end
                default: s_nxt.txb = s_r.txb;
            endcase
        end

        // transfer engine; disabled port returns to idle
        if (!en) begin
            s_nxt.st = SSP_IDLE;
            s_nxt.sck_int = 1'b0;
            s_nxt.bitcnt = 5'h00;
            s_nxt.fs_pend = 1'b0;
        end else if (!halted) begin
            unique case (s_r.st)
                SSP_IDLE: begin
                    s_nxt.bitcnt = 5'h00;
                    s_nxt.div = 8'h00;
                    s_nxt.sck_int = 1'b0;
                    // in master mode a pending word goes into the shifter before the clock runs
                    if (s_r.stat[`SSP_STAT_TBF] && !s_r.stat[`SSP_STAT_ROV]) begin
                        if (master) begin
                            s_nxt.shreg = s_r.txb;
                            s_nxt.stat[`SSP_STAT_TBF] = req.wr && req.addr == `SSP_ADDR_BUF;
                            s_nxt.st = SSP_SHIFT;
                            s_nxt.fs_pend = framed & ~s_r.con2[`SSP_C2_FSD];
                        end
                    end
                    if (!master && !s_r.stat[`SSP_STAT_ROV] && ss_ok) begin
                        if (!framed || (fs_act && !s_r.ss_prev)) begin
                            s_nxt.st = SSP_SHIFT;
                        end
                    end
                end
                SSP_SHIFT: begin
                    // master generates its own clock from the prescalers
                    if (master) begin
                        if ({1'b0, s_r.div} + 9'h001 >= hp) begin
                            s_nxt.div = 8'h00;
                            s_nxt.sck_int = ~s_r.sck_int;
                            do_sample = ~s_r.sck_int;
                            do_shift = s_r.sck_int;
                        end else begin
                            s_nxt.div = s_r.div + 8'h01;
                        end
                        if (do_shift) begin
                            s_nxt.fs_pend = 1'b0;
                        end
                    end else if (!s_r.stat[`SSP_STAT_ROV]) begin
                        do_sample = lead_edge;
                        do_shift = trail_edge;
                    end
                    // edge select swaps which edge samples and which shifts
                    if (cke) begin
                        {do_sample, do_shift} = {do_shift, do_sample};
                    end
                    if (do_sample) begin
                        s_nxt.shreg = {s_r.shreg[14:0], pins_in.sdi_i};
                        s_nxt.bitcnt = s_r.bitcnt + 5'h01;
                        word_end = (s_r.bitcnt + 5'h01) == nbits;
                    end
                    if (word_end) begin
                        s_nxt.st = SSP_DONE;
                    end
                end
                SSP_DONE: begin
                    // let the last half clock finish before handing over
                    if (!master || s_r.sck_int == 1'b0 || cke) begin
                        s_nxt.sck_int = 1'b0;
                        s_nxt.st = SSP_IDLE;
                        s_nxt.ev.done_flag = 1'b1;
                        if (s_r.stat[`SSP_STAT_RBF]) begin
                            s_nxt.stat[`SSP_STAT_ROV] = 1'b1;
                            s_nxt.ev.err_irq = 1'b1;
                        end else begin
                            s_nxt.rxb = s_r.con1[`SSP_C1_WORD_SIZE_SELECT] ? s_r.shreg
                                : {8'h00, s_r.shreg[7:0]};
                            s_nxt.stat[`SSP_STAT_RBF] = 1'b1;
                        end
                        // slave preloads the next word once the copy is done
                        if (!master && s_r.stat[`SSP_STAT_TBF]) begin
                            s_nxt.shreg = s_r.txb;
                            // a buffer write in this very cycle keeps the flag up
                            s_nxt.stat[`SSP_STAT_TBF] = req.wr && req.addr == `SSP_ADDR_BUF;
                        end
                    end else if ({1'b0, s_r.div} + 9'h001 >= hp) begin
                        s_nxt.div = 8'h00;
                        s_nxt.sck_int = 1'b0;
                    end else begin
                        s_nxt.div = s_r.div + 8'h01;
                    end
                end
                default: s_nxt.st = SSP_IDLE;
            endcase
        end

        // pin drive; disables release the pins to port control
        s_nxt.pins.sck_oe = en & master & ~s_nxt.con1[`SSP_C1_CLOCK_OUTPUT_DISABLE];
        s_nxt.pins.sck_o = s_nxt.sck_int ^ s_nxt.con1[`SSP_C1_CKP];
        s_nxt.pins.sdo_oe = en & ~s_nxt.con1[`SSP_C1_DATA_OUTPUT_DISABLE];
        s_nxt.pins.sdo_o = s_nxt.con1[`SSP_C1_WORD_SIZE_SELECT] ? s_nxt.shreg[15] : s_nxt.shreg[7];
        s_nxt.pins.ss_oe = en & framed & ~s_nxt.con2[`SSP_C2_FSD];
        // edge bit set or clear: pulse rides the first bit, from shifter start to its shift edge
        s_nxt.pins.ss_o = s_nxt.con2[`SSP_C2_FPOL] ~^ (s_nxt.fs_pend
            & (s_nxt.con2[`SSP_C2_FDLY] | s_nxt.st == SSP_SHIFT));
        s_nxt.ev.done_irq = s_nxt.ev.done_flag & done_enable;
    end

    // one register for the entire state
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s_r <= '{st: SSP_IDLE, stat: `SSP_REG_RESET, con1: `SSP_REG_RESET,
                con2: `SSP_REG_RESET, pins: '{ss_o: 1'b1, default: 1'b0}, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign pins_out = s_r.pins;
    assign events = s_r.ev;
endmodule

// ===== hw/ssp_defines.svh
// register offsets, field positions, reset values and word lengths of the serial port
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
// word addresses on the plain register port
`define SSP_ADDR_STAT 4'h0
`define SSP_ADDR_CON1 4'h1
`define SSP_ADDR_CON2 4'h2
`define SSP_ADDR_BUF 4'h3
// status register fields
`define SSP_STAT_EN 15
`define SSP_STAT_SIDL 13
`define SSP_STAT_ROV 6
`define SSP_STAT_TBF 1
`define SSP_STAT_RBF 0
// control register one fields
`define SSP_C1_CLOCK_OUTPUT_DISABLE 12
`define SSP_C1_DATA_OUTPUT_DISABLE 11
`define SSP_C1_WORD_SIZE_SELECT 10
`define SSP_C1_SMP 9
`define SSP_C1_CKE 8
`define SSP_C1_SELECT_INPUT_ENABLE 7
`define SSP_C1_CKP 6
`define SSP_C1_MASTER_SELECT 5
`define SSP_C1_SPRE_LO 2
`define SSP_C1_PPRE_LO 0
// control register two fields
`define SSP_C2_FRAMED_MODE_ENABLE 15
`define SSP_C2_FSD 14
`define SSP_C2_FPOL 13
`define SSP_C2_FDLY 1
// writable masks and reset values
`define SSP_STAT_WMASK 16'hA000
`define SSP_C1_WMASK 16'h1FFF
`define SSP_C2_WMASK 16'hE002
`define SSP_REG_RESET 16'h0000
// word lengths in bits
`define SSP_BITS_BYTE 5'h08
`define SSP_BITS_WORD 5'h10
`endif

// ===== hw/ssp_pkg.sv
// types shared by the serial port design
package ssp_pkg;
    typedef enum logic [2:0] {
        SSP_IDLE = 3'b001,
        SSP_SHIFT = 3'b010,
        SSP_DONE = 3'b100
    } ssp_state_t;

    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ssp_req_t;

    // serial pins seen from the block, three signals per two-way pin
    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic sdo_o;
        logic sdo_oe;
        logic ss_o;
        logic ss_oe;
    } ssp_pins_out_t;

    typedef struct packed {
        logic sck_i;
        logic sdi_i;
        logic ss_i;
    } ssp_pins_in_t;

    // event outputs
    typedef struct packed {
        logic done_flag;
        logic done_irq;
        logic err_irq;
    } ssp_events_t;
endpackage

// ===== dv/ssp_port_props.sv
// checker with port-level properties of the serial port
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_port_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // watched ports
    input wire logic dev_idle,
    input wire ssp_pkg::ssp_req_t req,
    input wire logic [15:0] rdata,
    input wire ssp_pkg::ssp_pins_in_t pins_in,
    input wire ssp_pkg::ssp_pins_out_t pins_out,
    input wire ssp_pkg::ssp_events_t events,
    input wire logic done_enable
);
    import ssp_pkg::*;
    logic [15:0] stat_r, con1_r;
    logic off, slv, nosdo, halt;
    // mirror of written settings; pins may lag a write by two edges
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            stat_r <= 16'h0000;
            con1_r <= 16'h0000;
        end else if (req.wr && req.addr == `SSP_ADDR_STAT) begin
            stat_r <= req.wdata;
        end else if (req.wr && req.addr == `SSP_ADDR_CON1) begin
            con1_r <= req.wdata;
        end
    end
    assign off = !stat_r[`SSP_STAT_EN];
    assign slv = stat_r[`SSP_STAT_EN] && !con1_r[`SSP_C1_MASTER_SELECT];
    assign nosdo = con1_r[`SSP_C1_DATA_OUTPUT_DISABLE];
    assign halt = stat_r[`SSP_STAT_EN] && stat_r[`SSP_STAT_SIDL] && dev_idle;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    chk_rd_quiet: assert property (
        !$past(req.rd) |-> rdata == 16'h0000) else $error("read data without read");
    chk_stat_unused: assert property (
        $past(req.rd && req.addr == `SSP_ADDR_STAT) |-> (rdata & 16'h5FBC) == 16'h0000)
        else $error("unused status bits not zero");
    chk_done_pulse: assert property (
        events.done_flag |=> !events.done_flag) else $error("done flag too long");
    chk_done_irq: assert property (
        events.done_irq |-> events.done_flag && $past(done_enable))
        else $error("done interrupt without cause");
    chk_err_pulse: assert property (
        events.err_irq |=> !events.err_irq) else $error("error interrupt too long");
    chk_off_quiet: assert property (
        off && $past(off) && $past(off, 2) |-> !pins_out.sck_oe && !pins_out.sdo_oe)
        else $error("disabled port drives pins");
    chk_slave_clk: assert property (
        slv && $past(slv) && $past(slv, 2) |-> !pins_out.sck_oe)
        else $error("slave drives shift clock");
    chk_sdo_free: assert property (
        nosdo && $past(nosdo) && $past(nosdo, 2) |-> !pins_out.sdo_oe)
        else $error("disabled data out still driven");
    chk_idle_halt: assert property (
        halt && $past(halt) && $past(halt, 2) |-> $stable(pins_out.sck_o))
        else $error("shift clock moves while halted");
    cov_done_irq: cover property (events.done_irq);
    cov_overflow: cover property (events.err_irq);
    cov_halted: cover property (halt ##1 halt);
endmodule

bind ssp_port ssp_port_props ssp_port_props_i (.core_clk(core_clk), .resetn(resetn),
    .dev_idle(dev_idle), .req(req), .rdata(rdata), .pins_in(pins_in),
    .pins_out(pins_out), .events(events), .done_enable(done_enable));

// ===== dv/ssp_far_end.sv
// far-end serial peripheral answering the port in master mode
`timescale 1ns/10ps
module ssp_far_end (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // word set-up and result
    input wire logic wide,
    input wire logic [15:0] tx_word,
    output logic [15:0] rx_word,
    // serial lines
    input wire logic sck,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    output logic sdi
);
    logic [15:0] sh_r, rx_r;
    logic [4:0] cnt_r;
    logic sck_d, sdo_last;
    logic sdo_w;
    // released data out has no pull, so it shows a toggling pattern
    assign sdo_w = sdo_oe ? sdo_o : ~sdo_last;
    assign sdi = sh_r[15];
    // sample on rising shift clock, advance on falling, msb first
    always @(posedge core_clk) begin
        sck_d <= sck;
        sdo_last <= sdo_w;
        if (!resetn) begin
            sh_r <= wide ? tx_word : {tx_word[7:0], 8'h00};
            cnt_r <= 5'h00;
            rx_r <= 16'h0000;
            rx_word <= 16'h0000;
        end else if (sck && !sck_d) begin
            // the port moves data out on the same edge, so take the level held before it
            rx_r <= {rx_r[14:0], sdo_last};
            cnt_r <= cnt_r + 5'h01;
        end else if (!sck && sck_d) begin
            if (cnt_r == (wide ? 5'h10 : 5'h08)) begin
                rx_word <= wide ? rx_r : {8'h00, rx_r[7:0]};
                sh_r <= wide ? tx_word : {tx_word[7:0], 8'h00};
                cnt_r <= 5'h00;
            end else begin
                sh_r <= {sh_r[14:0], 1'b0};
            end
        end
    end
endmodule

// ===== dv/test_ssp_port.sv
// self-checking testbench of the serial port in master mode
`timescale 1ns/10ps
`include "ssp_defines.svh"
module test_ssp_port;
    import ssp_pkg::*;
    logic core_clk, resetn, dev_idle, done_enable, wide, sdi, sck_d, hit, irq;
    logic [15:0] rdata, rx_word, tx, v;
    ssp_req_t req;
    ssp_pins_in_t pins_in;
    ssp_pins_out_t pins_out;
    ssp_events_t events;
    int fails, num_checks, rises, per, last_t, cyc;
    // wire levels: shift clock idles low, select pulled up
    assign pins_in.sck_i = pins_out.sck_oe ? pins_out.sck_o : 1'b0;
    assign pins_in.ss_i = pins_out.ss_oe ? pins_out.ss_o : 1'b1;
    assign pins_in.sdi_i = sdi;
    ssp_port ssp_port_i (.core_clk(core_clk), .resetn(resetn), .dev_idle(dev_idle),
        .req(req), .rdata(rdata), .pins_in(pins_in), .pins_out(pins_out),
        .events(events), .done_enable(done_enable));
    ssp_far_end ssp_far_end_i (.core_clk(core_clk), .resetn(resetn), .wide(wide),
        .tx_word(tx), .rx_word(rx_word), .sck(pins_in.sck_i), .sdo_o(pins_out.sdo_o),
        .sdo_oe(pins_out.sdo_oe), .sdi(sdi));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // shift clock rising edges: count and last spacing in cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        sck_d <= pins_in.sck_i;
        if (pins_in.sck_i && !sck_d) begin
            rises <= rises + 1;
            per <= cyc - last_t;
            last_t <= cyc;
        end
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk) req.wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task rdc(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk) req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge core_clk) req.rd <= 1'b0;
        @(negedge core_clk) chk(rdata, exp);
    endtask
    // fresh reset, then control before enable
    task start(input logic [15:0] c1, input logic [15:0] st);
        @(posedge core_clk) resetn <= 1'b0;
        rises <= 0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        wr(`SSP_ADDR_CON1, c1);
        wr(`SSP_ADDR_STAT, st);
    endtask
    task wait_ev(input int n, input logic err);
        hit = 1'b0;
        irq = 1'b0;
        repeat (n) begin
            @(negedge core_clk);
            if (err ? events.err_irq : events.done_flag) begin
                hit = 1'b1;
                irq = events.done_irq;
                break;
            end
        end
    endtask
    task t_regs;
        start(16'h0000, 16'h0000);
        rdc(`SSP_ADDR_CON1, 16'h0000);
        wr(`SSP_ADDR_CON2, 16'hFFFF);
        rdc(`SSP_ADDR_CON2, 16'hE002);
        wr(`SSP_ADDR_CON1, 16'hFFFF);
        rdc(`SSP_ADDR_CON1, 16'h1FFF);
        wr(4'h7, 16'hFFFF);
        rdc(4'h7, 16'h0000);
        wr(`SSP_ADDR_CON1, 16'h0000);
        wr(`SSP_ADDR_STAT, 16'hFFFF);
        rdc(`SSP_ADDR_STAT, 16'hA000);
        $display("registers done");
    endtask
    task t_master;
        wide = 1'b1;
        done_enable = 1'b1;
        start(16'h0433, 16'h8000);
        wr(`SSP_ADDR_BUF, 16'hA5C3);
        repeat (8) @(posedge core_clk);
        wr(`SSP_ADDR_BUF, 16'h0F1E);
        rdc(`SSP_ADDR_STAT, 16'h8002);
        wait_ev(200, 1'b0);
        chk({15'h0, hit}, 16'h0001);
        chk({15'h0, irq}, 16'h0001);
        rdc(`SSP_ADDR_STAT, 16'h8001);
        chk(rx_word, 16'hA5C3);
        rdc(`SSP_ADDR_BUF, 16'h3C5A);
        rdc(`SSP_ADDR_STAT, 16'h8000);
        @(posedge core_clk) done_enable <= 1'b0;
        wait_ev(200, 1'b0);
        chk({15'h0, irq}, 16'h0000);
        repeat (8) @(posedge core_clk);
        chk(rx_word, 16'h0F1E);
        $display("master done");
    endtask
    task t_overflow;
        wide = 1'b0;
        start(16'h0033, 16'h8000);
        wr(`SSP_ADDR_BUF, 16'h0011);
        wait_ev(100, 1'b0);
        chk({15'h0, hit}, 16'h0001);
        tx = 16'h3CA5;
        wr(`SSP_ADDR_BUF, 16'h0022);
        wait_ev(100, 1'b1);
        chk({15'h0, hit}, 16'h0001);
        rdc(`SSP_ADDR_STAT, 16'h8041);
        wr(`SSP_ADDR_BUF, 16'h0033);
        wait_ev(100, 1'b0);
        chk({15'h0, hit}, 16'h0000);
        rdc(`SSP_ADDR_BUF, 16'h005A);
        tx = 16'h3C5A;
        $display("overflow done");
    endtask
    task t_rates;
        wide = 1'b0;
        for (int p = 0; p < 4; p++) begin
            start(16'h0030 | 16'(p), 16'h8000);
            wr(`SSP_ADDR_BUF, 16'h0055);
            wait_ev(2200, 1'b0);
            chk({15'h0, hit}, 16'h0001);
            chk(16'(per), 16'(1 << (2 * (4 - p))));
            chk(16'(rises), 16'h0008);
        end
        $display("rates done");
    endtask
    task t_idle;
        wide = 1'b0;
        start(16'h0833, 16'hA000);
        @(posedge core_clk) dev_idle <= 1'b1;
        wr(`SSP_ADDR_BUF, 16'h0066);
        wait_ev(120, 1'b0);
        chk({15'h0, hit}, 16'h0000);
        @(posedge core_clk) dev_idle <= 1'b0;
        wait_ev(120, 1'b0);
        chk({15'h0, hit}, 16'h0001);
        start(16'h0033, 16'h0000);
        wr(`SSP_ADDR_BUF, 16'h0077);
        wait_ev(100, 1'b0);
        chk({15'h0, hit}, 16'h0000);
        $display("idle done");
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // a hang counts as a mismatch
    initial begin
        #200000;
        fails++;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up;
    end
    initial begin
        resetn = 1'b0;
        dev_idle = 1'b0;
        done_enable = 1'b0;
        wide = 1'b0;
        req = '0;
        tx = 16'h3C5A;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        t_regs;
        t_master;
        t_overflow;
        t_rates;
        t_idle;
        wrap_up;
    end
endmodule
